// ===== rtl/imsc_pkg.sv
// Constants shared by the internal memory, SFR decode and code access logic
// Notes on behaviour
// - Bytes 0x00-0x1F are four banks R0
// - Sixteen bytes from 0x20 hold 128 addressable bits
// - Scratchpad of 80 bytes above bit area
// - Lower RAM reachable direct and indirect
// - Indirect 0x80-0xFF reaches upper RAM
// - Direct 0x80-0xFF reaches special function registers
// - SFRs ending in nibble 0 or 8 bit-addressable
// - Code write strobes only if write enable set when request taken
// - Pointer write stores accumulator at pointer address
// - Ri write uses port2 high, Ri low
// - Wait field for fetch/MOVC; writes use data wait
// - Wait field 7..4 gives 8..5 clocks
// - Code read lasts four to eight clocks
// - Code write takes at least four clocks
package imsc_pkg;
  // Register addresses in direct SFR space
  localparam logic [7:0] SFR_POWER_AND_PROGRAM_WRITE_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] SFR_CODE_MEMORY_WAIT_STATES_ADDR = 8'h92;
  // Reset values and writable bits
  localparam logic [7:0] POWER_AND_PROGRAM_WRITE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_AND_PROGRAM_WRITE_CONTROL_WR_MASK = 8'h90;
  localparam logic [2:0] CODE_MEMORY_WAIT_STATES_RESET = 3'h7;
  localparam int POWER_AND_PROGRAM_WRITE_CONTROL_PWE_BIT = 4;
  localparam int POWER_AND_PROGRAM_WRITE_CONTROL_BAUD_BIT = 7;
  // Internal RAM landmarks
  localparam logic [7:0] BANK_BASE = 8'h00;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] SCRATCH_BASE = 8'h30;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  // Code timing in clocks
  localparam logic [3:0] CODE_RD_MIN = 4'h4;
  localparam logic [3:0] CODE_RD_MAX = 4'h8;
  localparam logic [2:0] CODE_MEMORY_WAIT_STATES_FIRST_USED = 3'h4;
  localparam logic [3:0] CODE_WR_MIN = 4'h4;
  // Code access sequencer, Gray coded along idle-read-done
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_READ = 2'h1,
    CS_DONE = 2'h3,
    CS_WRITE = 2'h2
  } imsc_code_state_t;
endpackage

// ===== rtl/imsc_ram.sv
// Internal data RAM: flip-flop array, one write port, two read ports
`timescale 1ns/1ns
module imsc_ram
  import imsc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);
  // Storage array, indexed by byte address
  logic [WIDTH-1:0] mem_reg [DEPTH];
  localparam int ADDR_W = $clog2(DEPTH); // Index width, matches the port width

  // Lower half needs the bank, bit and scratch areas below upper base
  if (DEPTH < 2 * UPPER_BASE || WIDTH < 1)
  begin : g_bad_size
    $error("imsc_ram: depth must cover lower and upper RAM");
  end

  // Reads are combinational so the caller registers them once
  assign rdata_a = mem_reg[raddr_a];
  assign rdata_b = mem_reg[raddr_b];

  // Each word is its own flop group with a decoded enable
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_reg[i] <= '0;
      else if (we && waddr == ADDR_W'(i))
        mem_reg[i] <= wdata;
    end
  end
endmodule

// ===== rtl/imsc_core.sv
// Internal RAM and SFR decode with code memory read/write sequencing
`timescale 1ns/1ns
module imsc_core
  import imsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Core data access: byte or bit, direct or indirect
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_indirect,
  input wire logic mem_bit,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ready,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic bit_rdata,
  // Outside SFR bus for registers not held here
  output logic [7:0] sfr_addr,
  output logic sfr_rd,
  output logic sfr_we,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Control bits held here
  output logic program_write_enable,
  output logic serial_baud_double,
  output logic [2:0] code_wait_field,
  // Core context for code writes
  input wire logic [7:0] acc,
  input wire logic [15:0] active_data_pointer,
  input wire logic [7:0] port2_high_address,
  input wire logic [1:0] reg_bank,
  input wire logic [2:0] data_wait_control,
  // Code fetch / MOVC read and MOVX code write requests
  input wire logic code_rd_req,
  input wire logic [15:0] code_rd_addr,
  input wire logic code_wr_req,
  input wire logic code_wr_use_active_data_pointer,
  input wire logic code_wr_ri,
  output logic code_busy,
  output logic code_done,
  output logic [7:0] code_rdata,
  // Code memory pins
  output logic [15:0] code_addr,
  output logic [7:0] code_wdata,
  output logic code_rd,
  output logic code_wr,
  input wire logic [7:0] code_memory_state
);
  // Direct access above 0x7f means SFR space
  function automatic logic is_sfr(input logic indirect, input logic [7:0] addr);
    is_sfr = !indirect && (addr >= UPPER_BASE);
  endfunction
  // Bit address to the byte that holds it
  function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
    if (baddr >= UPPER_BASE)
      bit_byte = {baddr[7:3], 3'h0};
    else
      bit_byte = BIT_AREA_BASE + {4'h0, baddr[6:3]};
  endfunction
  // Decode of the two registers that live in this block
  function automatic logic is_local(input logic [7:0] addr);
    is_local = (addr == SFR_POWER_AND_PROGRAM_WRITE_CONTROL_ADDR) || (addr == SFR_CODE_MEMORY_WAIT_STATES_ADDR);
  endfunction
  // Control registers
  logic [7:0] power_and_program_write_control_reg, power_and_program_write_control_next; // Power and program write control
  logic [2:0] code_memory_wait_states_reg, code_memory_wait_states_next; // Code wait field
  // Data access pipeline: take, then decode and answer
  logic ready_reg; // High when a request may be taken
  logic s1_reg; // Access in decode stage
  logic s1_we_reg;
  logic s1_ind_reg;
  logic s1_bit_reg;
  logic [2:0] s1_pos_reg; // Bit position within byte
  logic [7:0] s1_wdata_reg;
  logic [7:0] addr_reg; // Byte address, also SFR bus address
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic bit_rdata_reg;
  logic sfr_rd_reg;
  logic sfr_we_reg;
  logic [7:0] sfr_wdata_reg;
  // Take-time decode
  wire take = mem_req && ready_reg;
  wire [7:0] take_byte = mem_bit ? bit_byte(mem_addr) : mem_addr;
  wire take_sfr = mem_bit ? (mem_addr >= UPPER_BASE) : is_sfr(mem_indirect, mem_addr);
  wire take_ext = take_sfr && !is_local(take_byte);
  // Bit writes read first, so they need the outside value too
  wire take_ext_rd = take && take_ext && (!mem_we || mem_bit);
  // Decode-stage steering
  wire s1_sfr = s1_bit_reg ? (addr_reg >= UPPER_BASE) : is_sfr(s1_ind_reg, addr_reg);
  wire s1_power_and_program_write_control = s1_sfr && (addr_reg == SFR_POWER_AND_PROGRAM_WRITE_CONTROL_ADDR);
  wire s1_code_memory_wait_states = s1_sfr && (addr_reg == SFR_CODE_MEMORY_WAIT_STATES_ADDR);
  wire s1_ext = s1_sfr && !s1_power_and_program_write_control && !s1_code_memory_wait_states;
  wire [7:0] ram_rdata_a;
  wire [7:0] ram_rdata_b;
  wire [7:0] rd_byte = s1_ext ? sfr_rdata :
                       s1_power_and_program_write_control ? power_and_program_write_control_reg :
                       s1_code_memory_wait_states ? {5'h00, code_memory_wait_states_reg} : ram_rdata_a;
  // Bit write is a read-modify-write of the holding byte
  wire [7:0] bit_mask = 8'h01 << s1_pos_reg;
  wire [7:0] bit_merged = s1_wdata_reg[0] ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
  wire [7:0] wr_byte = s1_bit_reg ? bit_merged : s1_wdata_reg;
  wire s1_write = s1_reg && s1_we_reg;
  // RAM holds banks, bit area, scratch and upper indirect bytes
  wire ram_we = s1_write && !s1_sfr;
  // Code access sequencer
  imsc_code_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next; // Clocks left in the strobe
  logic [15:0] caddr_reg, caddr_next; // Code address, held per access
  logic [7:0] cwdata_reg, cwdata_next; // Byte to be written
  logic crd_reg, crd_next; // Read strobe
  logic cwr_reg, cwr_next; // Write strobe
  logic cdone_reg, cdone_next; // End-of-access pulse
  logic [7:0] crdata_reg, crdata_next; // Byte read back
  // Read length: unused field values clamp to the 4-clock floor
  wire [3:0] rd_clocks = (code_memory_wait_states_reg < CODE_MEMORY_WAIT_STATES_FIRST_USED) ? CODE_RD_MIN
                         : {1'b0, code_memory_wait_states_reg} + 4'h1;
  // Write length follows the data wait control, never under four
  wire [3:0] wr_clocks = CODE_WR_MIN + {1'b0, data_wait_control};
  // Ri value read from the selected bank
  wire [7:0] ri_index = BANK_BASE + {3'h0, reg_bank, 2'h0, code_wr_ri};
  wire [15:0] wr_target = code_wr_use_active_data_pointer ? active_data_pointer
                          : {port2_high_address, ram_rdata_b};
  // Internal RAM
  imsc_ram #(
    .WIDTH(8),
    .DEPTH(256)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .we(ram_we),
    .waddr(addr_reg),
    .wdata(wr_byte),
    .raddr_a(addr_reg),
    .rdata_a(ram_rdata_a),
    .raddr_b(ri_index),
    .rdata_b(ram_rdata_b)
  );
  // Local register writes; reserved and unused bits forced to zero
  assign power_and_program_write_control_next = (s1_write && s1_power_and_program_write_control) ? (wr_byte & POWER_AND_PROGRAM_WRITE_CONTROL_WR_MASK) : power_and_program_write_control_reg;
  assign code_memory_wait_states_next = (s1_write && s1_code_memory_wait_states) ? wr_byte[2:0] : code_memory_wait_states_reg;
  // Control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_and_program_write_control_reg <= POWER_AND_PROGRAM_WRITE_CONTROL_RESET;
      code_memory_wait_states_reg <= CODE_MEMORY_WAIT_STATES_RESET;
    end
    else
    begin
      power_and_program_write_control_reg <= power_and_program_write_control_next;
      code_memory_wait_states_reg <= code_memory_wait_states_next;
    end
  end
  // Request capture; one bubble between requests keeps SFR address stable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b1;
      s1_reg <= 1'b0;
      s1_we_reg <= 1'b0;
      s1_ind_reg <= 1'b0;
      s1_bit_reg <= 1'b0;
      s1_pos_reg <= 3'h0;
      s1_wdata_reg <= 8'h00;
      addr_reg <= 8'h00;
      sfr_rd_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= !take;
      s1_reg <= take;
      sfr_rd_reg <= take_ext_rd;
      // Hold fields between requests
      if (take)
      begin
        s1_we_reg <= mem_we;
        s1_ind_reg <= mem_indirect;
        s1_bit_reg <= mem_bit;
        s1_pos_reg <= mem_addr[2:0];
        s1_wdata_reg <= mem_wdata;
        addr_reg <= take_byte;
      end
    end
  end
  // Answer stage and outside SFR write strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      bit_rdata_reg <= 1'b0;
      sfr_we_reg <= 1'b0;
      sfr_wdata_reg <= 8'h00;
    end
    else
    begin
      ack_reg <= s1_reg;
      sfr_we_reg <= s1_write && s1_ext;
      // Read data only changes on an answered access
      if (s1_reg)
      begin
        rdata_reg <= rd_byte;
        bit_rdata_reg <= rd_byte[s1_pos_reg];
        sfr_wdata_reg <= wr_byte;
      end
    end
  end
  // Code sequencer next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    caddr_next = caddr_reg;
    cwdata_next = cwdata_reg;
    crd_next = crd_reg;
    cwr_next = cwr_reg;
    cdone_next = 1'b0;
    crdata_next = crdata_reg;
    case (state_reg)
      CS_IDLE:
      begin
        // Reads win over a same-cycle write request
        if (code_rd_req)
        begin
          state_next = CS_READ;
          caddr_next = code_rd_addr;
          cnt_next = rd_clocks - 4'h1;
          crd_next = 1'b1;
        end
        else if (code_wr_req)
        begin
          caddr_next = wr_target;
          cwdata_next = acc;
          cnt_next = wr_clocks - 4'h1;
          // Without write enable the request completes with no strobe
          if (power_and_program_write_control_reg[POWER_AND_PROGRAM_WRITE_CONTROL_PWE_BIT])
          begin
            state_next = CS_WRITE;
            cwr_next = 1'b1;
          end
          else
            state_next = CS_DONE;
        end
      end
      CS_READ:
      begin
        if (cnt_reg == 4'h0)
        begin
          crd_next = 1'b0;
          crdata_next = code_memory_state;
          state_next = CS_DONE;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      CS_WRITE:
      begin
        if (cnt_reg == 4'h0)
        begin
          cwr_next = 1'b0;
          state_next = CS_DONE;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      CS_DONE:
      begin
        cdone_next = 1'b1;
        state_next = CS_IDLE;
      end
      default:
      begin
        state_next = CS_IDLE;
        crd_next = 1'b0;
        cwr_next = 1'b0;
      end
    endcase
  end
  // Code sequencer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= CS_IDLE;
      cnt_reg <= 4'h0;
      caddr_reg <= 16'h0000;
      cwdata_reg <= 8'h00;
      crd_reg <= 1'b0;
      cwr_reg <= 1'b0;
      cdone_reg <= 1'b0;
      crdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      caddr_reg <= caddr_next;
      cwdata_reg <= cwdata_next;
      crd_reg <= crd_next;
      cwr_reg <= cwr_next;
      cdone_reg <= cdone_next;
      crdata_reg <= crdata_next;
    end
  end
  // Busy from the cycle after take until the done pulse, taken from next state
  logic busy_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else
      busy_reg <= (state_next != CS_IDLE);
  end
  // Outputs straight from flops
  assign mem_ready = ready_reg;
  assign mem_ack = ack_reg;
  assign mem_rdata = rdata_reg;
  assign bit_rdata = bit_rdata_reg;
  assign sfr_addr = addr_reg;
  assign sfr_rd = sfr_rd_reg;
  assign sfr_we = sfr_we_reg;
  assign sfr_wdata = sfr_wdata_reg;
  assign program_write_enable = power_and_program_write_control_reg[POWER_AND_PROGRAM_WRITE_CONTROL_PWE_BIT];
  assign serial_baud_double = power_and_program_write_control_reg[POWER_AND_PROGRAM_WRITE_CONTROL_BAUD_BIT];
  assign code_wait_field = code_memory_wait_states_reg;
  assign code_busy = busy_reg;
  assign code_done = cdone_reg;
  assign code_rdata = crdata_reg;
  assign code_addr = caddr_reg;
  assign code_wdata = cwdata_reg;
  assign code_rd = crd_reg;
  assign code_wr = cwr_reg;
endmodule

// ===== verification/imsc_core_monitor.sv
// Checker for data answer timing, register space steering and code strobes
`timescale 1ns/1ns
module imsc_core_monitor
  import imsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic mem_ready,
  input wire logic mem_ack,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_we,
  input wire logic program_write_enable,
  input wire logic [2:0] code_wait_field,
  input wire logic code_rd,
  input wire logic code_wr,
  input wire logic code_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles the read strobe has stood so far
  logic [3:0] rd_len_reg;
  logic [3:0] rd_len_next;
  // Expected read length; unused field values give the shortest read
  logic [3:0] rd_exp;
  assign rd_len_next = code_rd ? rd_len_reg + 4'h1 : 4'h0;
  assign rd_exp = (code_wait_field > 3'h3) ? {1'b0, code_wait_field} + 4'h1 : 4'h4;
  // Cleared in reset so a read cut short is never measured
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_len_reg <= 4'h0;
    else
      rd_len_reg <= rd_len_next;
  end
  sequence s_take;
    mem_req && mem_ready;
  endsequence
  sequence s_answer;
    !mem_ready ##1 mem_ack;
  endsequence
  chk_ack_two_cycles: assert property (s_take |=> s_answer)
    else $error("data answer not two cycles after take");
  chk_read_length: assert property ($fell(code_rd) |-> rd_len_next == 4'h0 && rd_len_reg == rd_exp)
    else $error("read strobe length differs from wait field");
  chk_read_bounds: assert property ($fell(code_rd) |-> rd_len_reg inside {[4:8]})
    else $error("read strobe outside four to eight clocks");
  chk_read_done: assert property ($fell(code_rd) |=> code_done)
    else $error("read not closed by done pulse");
  chk_write_enable: assert property (code_wr |-> program_write_enable)
    else $error("code write strobe without write enable");
  chk_write_min: assert property ($rose(code_wr) |-> code_wr [*4])
    else $error("code write strobe shorter than four clocks");
  chk_write_done: assert property ($fell(code_wr) |=> code_done)
    else $error("write not closed by done pulse");
  chk_sfr_space: assert property (sfr_rd || sfr_we |-> sfr_addr[7] && sfr_addr != 8'h87 && sfr_addr != 8'h92)
    else $error("outside register strobe for wrong address");
  chk_strobe_apart: assert property (!(code_rd && code_wr))
    else $error("read and write strobes together");
  chk_sfr_write_ack: assert property (sfr_we |-> mem_ack && $past(sfr_rd, 1) == 1'b0 || mem_ack)
    else $error("outside write not with answer");
endmodule
bind imsc_core imsc_core_monitor u_mon (.clk, .rst_n, .mem_req, .mem_ready, .mem_ack, .sfr_addr,
  .sfr_rd, .sfr_we, .program_write_enable, .code_wait_field, .code_rd, .code_wr, .code_done);

// ===== verification/imsc_code_mem_model.sv
// Behavioural code memory behind the code read and write strobes
`timescale 1ns/1ns
module imsc_code_mem_model
(
  input wire logic clk,
  input wire logic [15:0] code_addr,
  input wire logic [7:0] code_wdata,
  input wire logic code_rd,
  input wire logic code_wr,
  output logic [7:0] code_memory_state
);
  logic [7:0] store [0:65535];
  logic [7:0] last_reg = 8'h00;
  // Unwritten cells hold a pattern made from their address
  initial
    for (int i = 0; i < 65536; i++)
      store[i] = i[7:0] ^ i[15:8];
  // Store while the write strobe stands; last byte kept for the idle bus
  always @(posedge clk)
  begin
    if (code_wr)
      store[code_addr] <= code_wdata;
    if (code_rd)
      last_reg <= store[code_addr];
  end
  // Released data bus shows the inverse so stale data never matches
  assign code_memory_state = code_rd ? store[code_addr] : ~last_reg;
endmodule

// ===== verification/imsc_core_tb.sv
// Self-checking bench for RAM and register decode plus code memory access
`timescale 1ns/1ns
module imsc_core_tb;
  // Stimulus
  logic clk = 1'b0, rst_n = 1'b0;
  logic mem_req = 1'b0, mem_we = 1'b0, mem_indirect = 1'b0, mem_bit = 1'b0;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, acc = 8'h00, port2_high_address = 8'h00;
  logic [15:0] active_data_pointer = 16'h0000, code_rd_addr = 16'h0000;
  logic [1:0] reg_bank = 2'h0;
  logic [2:0] data_wait_control = 3'h0, code_wait_field;
  logic code_rd_req = 1'b0, code_wr_req = 1'b0, code_wr_use_active_data_pointer = 1'b0, code_wr_ri = 1'b0;
  // Design outputs
  logic mem_ready, mem_ack, bit_rdata, sfr_rd, sfr_we, program_write_enable, serial_baud_double;
  logic code_busy, code_done, code_rd, code_wr;
  logic [7:0] mem_rdata, sfr_addr, sfr_wdata, sfr_rdata, code_rdata, code_wdata, code_memory_state;
  logic [15:0] code_addr;
  int fails = 0, n_checks = 0;
  // Outside register reads 0x5a; unselected bus shows the inverse
  assign sfr_rdata = sfr_rd ? 8'h5a : 8'ha5;
  always #20 clk = ~clk;
  imsc_core DUT (.clk, .rst_n, .mem_req, .mem_we, .mem_indirect, .mem_bit, .mem_addr, .mem_wdata,
    .mem_ready, .mem_ack, .mem_rdata, .bit_rdata, .sfr_addr, .sfr_rd, .sfr_we, .sfr_wdata,
    .sfr_rdata, .program_write_enable, .serial_baud_double, .code_wait_field, .acc,
    .active_data_pointer, .port2_high_address, .reg_bank, .data_wait_control, .code_rd_req,
    .code_rd_addr, .code_wr_req, .code_wr_use_active_data_pointer, .code_wr_ri, .code_busy, .code_done,
    .code_rdata, .code_addr, .code_wdata, .code_rd, .code_wr, .code_memory_state);
  imsc_code_mem_model u_code (.clk, .code_addr, .code_wdata, .code_rd, .code_wr,
    .code_memory_state);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One data access; request held until the take edge, answer bounded
  task automatic mem_op(input logic we, bt, ind, input logic [7:0] a, d, output logic [7:0] v,
    output logic b);
    int i;
    mem_we = we;
    mem_bit = bt;
    mem_indirect = ind;
    mem_addr = a;
    mem_wdata = d;
    mem_req = 1'b1;
    @(posedge clk);
    #1;
    mem_req = 1'b0;
    for (i = 0; i < 6 && mem_ack !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (mem_ack !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    v = mem_rdata;
    b = bit_rdata;
  endtask
  task automatic wr(input logic ind, input logic [7:0] a, d);
    logic [7:0] v;
    logic b;
    mem_op(1'b1, 1'b0, ind, a, d, v, b);
  endtask
  task automatic rd(input logic ind, input logic [7:0] a, output logic [7:0] v);
    logic b;
    mem_op(1'b0, 1'b0, ind, a, 8'h00, v, b);
  endtask
  // One code access; counts strobe cycles until the done pulse
  task automatic code_op(input logic is_rd, output int nr, output int nw, output int nc);
    int nb;
    nb = 0;
    nr = 0;
    nw = 0;
    code_rd_req = is_rd;
    code_wr_req = !is_rd;
    @(posedge clk);
    #1;
    code_rd_req = 1'b0;
    code_wr_req = 1'b0;
    for (nc = 1; nc < 40 && code_done !== 1'b1; nc++)
    begin
      nr += int'(code_rd === 1'b1);
      nw += int'(code_wr === 1'b1);
      nb += int'(code_busy === 1'b1);
      @(posedge clk);
      #1;
    end
    if (code_done !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    // Busy stands from the cycle after take up to the done pulse
    check("busy cycles", 16'(nb), 16'(nc - 1));
    check("busy at done", 16'(code_busy), 16'h0000);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    check("wait field", 16'(code_wait_field), 16'h0007);
    check("write enable", 16'(program_write_enable), 16'h0000);
    rd(1'b0, 8'h87, v);
    check("power reg", 16'(v), 16'h0000);
    rd(1'b0, 8'h92, v);
    check("wait reg", 16'(v), 16'h0007);
    $display("test reset done");
  endtask
  task automatic t_ram();
    logic [7:0] v;
    logic [7:0] adr [9] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h7f, 8'h80, 8'h90, 8'hff};
    // Lower bytes written direct, upper bytes indirect
    foreach (adr[i])
      wr(adr[i][7], adr[i], adr[i] ^ 8'h3c);
    foreach (adr[i])
    begin
      rd(1'b1, adr[i], v);
      check("ram byte", 16'(v), 16'(adr[i] ^ 8'h3c));
    end
    rd(1'b0, 8'h1f, v);
    check("bank byte", 16'(v), 16'h0023);
    rd(1'b0, 8'h90, v);
    check("outside byte", 16'(v), 16'h005a);
    wr(1'b0, 8'h90, 8'h11);
    check("outside write", 16'({sfr_we, sfr_wdata}), 16'h0111);
    check("outside addr", 16'(sfr_addr), 16'h0090);
    rd(1'b1, 8'h90, v);
    check("upper kept", 16'(v), 16'h00ac);
    $display("test ram done");
  endtask
  task automatic t_bits();
    logic [7:0] v;
    logic b;
    mem_op(1'b1, 1'b1, 1'b0, 8'h7f, 8'h01, v, b);
    check("old bit", 16'(b), 16'h0000);
    mem_op(1'b1, 1'b1, 1'b0, 8'h00, 8'h01, v, b);
    rd(1'b0, 8'h2f, v);
    check("top bit byte", 16'(v), 16'h0093);
    rd(1'b0, 8'h20, v);
    check("low bit byte", 16'(v), 16'h001d);
    mem_op(1'b1, 1'b1, 1'b0, 8'h90, 8'h01, v, b);
    check("merged reg", 16'({sfr_we, sfr_wdata}), 16'h015b);
    mem_op(1'b0, 1'b1, 1'b0, 8'h94, 8'h00, v, b);
    check("reg bit", 16'(b), 16'h0001);
    $display("test bits done");
  endtask
  task automatic t_code_rd();
    int nr, nw, nc;
    logic [2:0] f [5] = '{3'h7, 3'h4, 3'h5, 3'h6, 3'h0};
    // First pass runs on the reset setting
    foreach (f[i])
    begin
      if (i > 0)
        wr(1'b0, 8'h92, {5'h00, f[i]});
      code_rd_addr = 16'h1200 + 16'(i);
      code_op(1'b1, nr, nw, nc);
      check("read strobe", 16'(nr), (f[i] > 3'h3) ? 16'(f[i]) + 16'h1 : 16'h4);
      check("read byte", 16'(code_rdata), 16'(8'h12 ^ 8'(i)));
    end
    $display("test code read done");
  endtask
  task automatic t_code_wr();
    int nr, nw, nc;
    logic [7:0] v;
    acc = 8'h77;
    active_data_pointer = 16'h4321;
    code_wr_use_active_data_pointer = 1'b1;
    code_op(1'b0, nr, nw, nc);
    check("blocked write", 16'(nw), 16'h0000);
    check("blocked length", 16'(nc), 16'h0002);
    wr(1'b0, 8'h87, 8'hf0);
    rd(1'b0, 8'h87, v);
    check("power bits", 16'({program_write_enable, serial_baud_double, v}), 16'h0390);
    code_op(1'b0, nr, nw, nc);
    check("write strobe", 16'(nw), 16'h0004);
    check("pointer addr", code_addr, 16'h4321);
    check("write data", 16'(code_wdata), 16'h0077);
    reg_bank = 2'h2;
    code_wr_ri = 1'b1;
    code_wr_use_active_data_pointer = 1'b0;
    port2_high_address = 8'ha6;
    data_wait_control = 3'h2;
    wr(1'b0, 8'h11, 8'h5c);
    code_op(1'b0, nr, nw, nc);
    check("slow strobe", 16'(nw), 16'h0006);
    check("register addr", code_addr, 16'ha65c);
    code_rd_addr = 16'h4321;
    code_op(1'b1, nr, nw, nc);
    check("stored byte", 16'(code_rdata), 16'h0077);
    $display("test code write done");
  endtask
  // Mid-run reset must bring back the slow wait field and clear state
  task automatic t_rereset();
    logic [7:0] v;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("wait field again", 16'(code_wait_field), 16'h0007);
    check("enable again", 16'(program_write_enable), 16'h0000);
    rd(1'b1, 8'h11, v);
    check("ram cleared", 16'(v), 16'h0000);
    rd(1'b0, 8'h92, v);
    check("wait reg again", 16'(v), 16'h0007);
    $display("test second reset done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_ram();
    t_bits();
    t_code_rd();
    t_code_wr();
    t_rereset();
    wrap_up();
  end
endmodule
